// ===== rtl/ssrc_run_control.sv
// What this block does
// - Kick allowed in both start profiles
// - Kick pulse at start, at most 2 s
// - Zero kick time skips kick
// - Current limit holds initial-torque voltage
// - Soft stop ramps voltage to zero
// - Network start needs network control and enable
// - Network start and stop ignored while local control active
// - Inputs 1-4 remappable, enable input fixed
// - No operation without run enable
// - Enable drop starts configured stop, coasts in jog
// - Start pulse launches start, holding harmless
// - Level mode restarts on enable return
// - Level auto mode restarts after fault clears
// - Jog starts but never closes bypass
// - Jog release always coasts
// - Local input or setting permits terminal starts
// - Reset clears fault only when inactive
// - Network reset command also clears fault
// - Edge mode needs start re-edge after fault
// - Sensing from switch, shown in status
// - Level auto restart needs all conditions
// - Level momentary restart needs new pulse
// - Display start and stop accepted
// - Reset mode codes manual, auto, power-up
// - Edge sensing by default
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`include "ssrc_regs.svh"

module ssrc_run_control
  import ssrc_pkg::*;
#(
  parameter int TICK_CYC = `SSRC_TICK_CYC,
  parameter int DEB_CYC  = `SSRC_DEB_CYC
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        runEnableIn,
  input  wire logic [3:0]  termIn,
  input  wire logic        sensingSelectSwitch,
  input  wire logic        faultActive,
  input  wire logic        atSpeed,
  input  wire ssrc_cmd_s   netCmd,
  input  wire ssrc_cmd_s   dispCmd,
  input  wire logic [4:0]  avAddress,
  input  wire logic        avRead,
  input  wire logic        avWrite,
  input  wire logic [31:0] avWritedata,
  output logic [31:0]      avReaddata,
  output logic             avWaitrequest,
  output ssrc_drive_s      drive,
  output ssrc_state_e      motorState,
  output logic             faultLatched
);

  localparam int TICK_W = $clog2(TICK_CYC);
  localparam int DEB_W  = $clog2(DEB_CYC);
  localparam logic [7:0] KICK_MAX = 8'(`SSRC_KICK_MAX_TK);

  logic [5:0]       rawIn;
  logic [5:0]       syncA;
  logic [5:0]       syncB;
  logic [5:0]       debIn;
  logic [DEB_W-1:0] debCnt [6];
  logic [TICK_W-1:0] tickCnt;
  logic             tick;
  ssrc_ctrl_s       ctrlReg;
  ssrc_level_s      levelReg;
  ssrc_time_s       timeReg;
  logic [3:0][1:0]  mapReg;
  logic             runEn;
  logic             levelSense;
  logic             fnStart;
  logic             fnJog;
  logic             fnLocal;
  logic             fnReset;
  logic             fnStartPrev;
  logic             localAct;
  logic             netOk;
  logic             startRise;
  logic             locStart;
  logic             goCmd;
  logic             jogCmd;
  logic             stopCmd;
  logic             resetReq;
  logic             puPend;
  logic             armed;
  logic             jogMode;
  logic             active;
  logic [7:0]       kickLen;
  logic [15:0]      cnt;
  logic [7:0]       rampV;
  logic [7:0]       stopFrom;
  logic [23:0]      acc;
  ssrc_status_s     status;

  // Sensing switch rides through the same conditioning as terminals
  assign rawIn = {sensingSelectSwitch, termIn, runEnableIn};

  // Two-flop synchroniser, then stable-count debounce per input
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      syncA   <= '0;
      syncB   <= '0;
      debIn   <= '0;
      for (int i = 0; i < 6; i++)
        debCnt[i] <= '0;
    end
    else
    begin
      syncA   <= rawIn;
      syncB   <= syncA;
      for (int i = 0; i < 6; i++)
      begin
        if (syncB[i] == debIn[i])
          debCnt[i] <= '0;
        else if (debCnt[i] == DEB_W'(DEB_CYC - 1))
        begin
          debIn[i]  <= syncB[i];
          debCnt[i] <= '0;
        end
        else
          debCnt[i] <= debCnt[i] + 1'b1;
      end
    end
  end

  // Enable terminal is hard-wired; switch low selects edge sensing
  assign runEn      = debIn[0];
  assign levelSense = debIn[5];

  // Map terminals 1-4 onto functions by configuration
  always_comb
  begin
    fnStart = 1'b0;
    fnJog   = 1'b0;
    fnLocal = 1'b0;
    fnReset = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      unique case (mapReg[i])
        `SSRC_FN_START: fnStart = fnStart | debIn[i+1];
        `SSRC_FN_JOG:   fnJog   = fnJog   | debIn[i+1];
        `SSRC_FN_LOCAL: fnLocal = fnLocal | debIn[i+1];
        `SSRC_FN_RESET: fnReset = fnReset | debIn[i+1];
      endcase
    end
  end

  // Previous start level for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      fnStartPrev <= 1'b0;
    else
      fnStartPrev <= fnStart;
  end

  // Time base: one-cycle tick every 10 ms
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tickCnt <= '0;
      tick    <= 1'b0;
    end
    else if (tickCnt == TICK_W'(TICK_CYC - 1))
    begin
      tickCnt <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      tickCnt <= tickCnt + 1'b1;
      tick    <= 1'b0;
    end
  end

  // Command arbitration
  assign localAct  = fnLocal | ctrlReg.localOnly;
  assign netOk     = ctrlReg.netCtl & ~localAct;
  assign startRise = fnStart & ~fnStartPrev;
  assign locStart  = levelSense
                   ? fnStart & (armed | ctrlReg.resetMode == RM_AUTO)
                   : startRise;
  assign goCmd  = runEn & ~faultLatched & ~faultActive
                & ((localAct & locStart) | (netOk & netCmd.start)
                   | dispCmd.start);
  assign jogCmd = runEn & ~faultLatched & ~faultActive
                & localAct & fnJog;
  assign stopCmd = ~runEn | (netOk & netCmd.stop) | dispCmd.stop;
  assign active  = motorState == ST_KICK || motorState == ST_RAMP
                || motorState == ST_RUN;
  assign kickLen = (levelReg.kickTime > KICK_MAX) ? KICK_MAX
                                                  : levelReg.kickTime;

  // Fault reset sources: terminal, network, display, auto, power-up
  assign resetReq = fnReset | netCmd.reset | dispCmd.reset
                  | ctrlReg.resetMode == RM_AUTO
                  | (puPend & tick & ctrlReg.resetMode == RM_PWRUP);

  // Fault latch; an active condition always wins over reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      faultLatched <= 1'b0;
      puPend       <= 1'b1;
    end
    else
    begin
      if (faultActive)
        faultLatched <= 1'b1;
      else if (resetReq)
        faultLatched <= 1'b0;
      if (tick)
        puPend <= 1'b0;
    end
  end

  // Re-arm tracking: lost on fault or on a network or display stop, regained when start drops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      armed <= 1'b1;
    else if (faultActive || (stopCmd && runEn))
      armed <= 1'b0;
    else if (!fnStart)
      armed <= 1'b1;
  end

  // Run sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      motorState <= ST_IDLE;
      jogMode    <= 1'b0;
      cnt        <= '0;
    end
    else
    begin
      unique case (motorState)
        ST_IDLE:
        begin
          cnt <= '0;
          if (goCmd || jogCmd)
          begin
            jogMode    <= ~goCmd;
            motorState <= (kickLen != 8'h00) ? ST_KICK : ST_RAMP;
          end
        end
        ST_KICK, ST_RAMP, ST_RUN:
        begin
          if (faultActive || faultLatched)
            motorState <= ST_IDLE;
          else if (jogMode && (!fnJog || !runEn || !localAct))
            motorState <= ST_IDLE;
          else if (!jogMode && stopCmd)
            motorState <= (ctrlReg.stopType == SP_SOFT
                        || ctrlReg.stopType == SP_PUMP) ? ST_STOP : ST_IDLE;
          else if (motorState == ST_KICK && tick)
          begin
            if (cnt >= 16'(kickLen) - 16'h0001)
            begin
              motorState <= ST_RAMP;
              cnt        <= '0;
            end
            else
              cnt <= cnt + 16'h0001;
          end
          else if (motorState == ST_RAMP)
          begin
            if (atSpeed)
              motorState <= ST_RUN;
            else if (ctrlReg.profile == PR_CLIMIT)
            begin
              if (cnt >= timeReg.startTime)
                motorState <= ST_RUN;
              else if (tick)
                cnt <= cnt + 16'h0001;
            end
            else if (rampV == `SSRC_V_FULL)
              motorState <= ST_RUN;
          end
        end
        ST_STOP:
        begin
          if (faultActive || faultLatched || rampV == `SSRC_V_ZERO)
            motorState <= ST_IDLE;
        end
        default:
          motorState <= ST_IDLE;
      endcase
    end
  end

  // Voltage ramps: accumulate per tick, step between ticks
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rampV    <= `SSRC_V_ZERO;
      stopFrom <= `SSRC_V_ZERO;
      acc      <= '0;
    end
    else
    begin
      if (motorState != ST_STOP)
        stopFrom <= rampV;
      unique case (motorState)
        ST_IDLE, ST_KICK:
        begin
          rampV <= levelReg.initTorque;
          acc   <= '0;
        end
        ST_RAMP:
        begin
          if (ctrlReg.profile == PR_CLIMIT)
            rampV <= levelReg.initTorque;
          else if (timeReg.startTime == 16'h0000)
            rampV <= `SSRC_V_FULL;
          else if (tick)
            acc <= acc + 24'(`SSRC_V_FULL - levelReg.initTorque);
          else if (acc >= 24'(timeReg.startTime) && rampV != `SSRC_V_FULL)
          begin
            acc   <= acc - 24'(timeReg.startTime);
            rampV <= rampV + 8'h01;
          end
        end
        ST_RUN:
        begin
          rampV <= `SSRC_V_FULL;
          acc   <= '0;
        end
        ST_STOP:
        begin
          if (timeReg.stopTime == 16'h0000)
            rampV <= `SSRC_V_ZERO;
          else if (tick)
            acc <= acc + 24'(stopFrom);
          else if (acc >= 24'(timeReg.stopTime) && rampV != `SSRC_V_ZERO)
          begin
            acc   <= acc - 24'(timeReg.stopTime);
            rampV <= rampV - 8'h01;
          end
        end
        default:
          rampV <= `SSRC_V_ZERO;
      endcase
    end
  end

  // Registered motor drive outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      drive <= '0;
    else
    begin
      drive.volt   <= (motorState == ST_IDLE) ? `SSRC_V_ZERO
                    : (motorState == ST_KICK) ? levelReg.kickTorque : rampV;
      drive.kick   <= motorState == ST_KICK;
      drive.bypass <= motorState == ST_RUN && !jogMode;
      drive.pump   <= motorState == ST_STOP && ctrlReg.stopType == SP_PUMP;
    end
  end

  // Live status word
  always_comb
  begin
    status            = '0;
    status.armed      = armed;
    status.jog        = jogMode;
    status.runEn      = runEn;
    status.localAct   = localAct;
    status.levelSense = levelSense;
    status.fault      = faultLatched;
    status.state      = motorState;
  end

  // Avalon slave: one wait cycle, answer on the second edge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      avWaitrequest <= 1'b1;
      avReaddata    <= '0;
    end
    else
    begin
      avWaitrequest <= ~((avRead | avWrite) & avWaitrequest);
      if (avRead && avWaitrequest)
      begin
        unique case (avAddress)
          `SSRC_OFS_CTRL:   avReaddata <= 32'(ctrlReg);
          `SSRC_OFS_LEVEL:  avReaddata <= 32'(levelReg);
          `SSRC_OFS_TIME:   avReaddata <= 32'(timeReg);
          `SSRC_OFS_MAP:    avReaddata <= 32'(mapReg);
          `SSRC_OFS_STATUS: avReaddata <= 32'(status);
          default:          avReaddata <= '0;
        endcase
      end
    end
  end

  // Configuration registers, written on the accepting edge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrlReg  <= ssrc_ctrl_s'(`SSRC_RST_CTRL);
      levelReg <= ssrc_level_s'(`SSRC_RST_LEVEL);
      timeReg  <= ssrc_time_s'(`SSRC_RST_TIME);
      mapReg   <= `SSRC_RST_MAP;
    end
    else if (avWrite && !avWaitrequest)
    begin
      unique case (avAddress)
        `SSRC_OFS_CTRL:  ctrlReg  <= ssrc_ctrl_s'(avWritedata[$bits(ssrc_ctrl_s)-1:0]);
        `SSRC_OFS_LEVEL: levelReg <= ssrc_level_s'(avWritedata[$bits(ssrc_level_s)-1:0]);
        `SSRC_OFS_TIME:  timeReg  <= ssrc_time_s'(avWritedata);
        `SSRC_OFS_MAP:   mapReg   <= avWritedata[$bits(mapReg)-1:0];
        default:         ;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_kick_skip: assert property ((motorState == ST_KICK && $past(motorState) == ST_IDLE)
    |-> $past(kickLen) != 8'h00) else $error("kick entered with zero time");
  a_kick_bound: assert property (motorState == ST_KICK |-> cnt < 16'(KICK_MAX))
    else $error("kick longer than limit");
  a_cl_hold: assert property ((motorState == ST_RAMP && ctrlReg.profile == PR_CLIMIT)
    ##1 motorState == ST_RAMP |-> rampV == $past(levelReg.initTorque))
    else $error("current limit voltage moved");
  a_enable_gate: assert property ((motorState == ST_IDLE && !runEn) |=> motorState == ST_IDLE)
    else $error("started without enable");
  a_enable_stop: assert property ((active && !jogMode && !runEn && !faultActive && !faultLatched)
    |=> motorState == ((ctrlReg.stopType == SP_SOFT || ctrlReg.stopType == SP_PUMP)
                       ? ST_STOP : ST_IDLE))
    else $error("enable drop did not stop");
  a_jog_bypass: assert property (jogMode |=> !drive.bypass)
    else $error("bypass during jog");
  a_jog_coast: assert property ((active && jogMode && !fnJog) |=> motorState == ST_IDLE)
    else $error("jog release not coast");
  a_fault_hold: assert property (faultActive |=> faultLatched)
    else $error("fault cleared while active");
  a_net_block: assert property ((motorState == ST_IDLE && localAct && !fnStart && !fnJog
    && !dispCmd.start) |=> motorState == ST_IDLE) else $error("network start while local");
  a_bus_answer: assert property ((avRead || avWrite) && avWaitrequest |=> !avWaitrequest ##1 avWaitrequest)
    else $error("bus answer timing");

  c_kick_start: cover property (motorState == ST_IDLE ##1 motorState == ST_KICK);
  c_soft_stop:  cover property (motorState == ST_STOP ##[1:1000] motorState == ST_IDLE);
  c_jog_run:    cover property (jogMode && motorState == ST_RUN);
  c_auto_rest:  cover property ($fell(faultLatched) ##[1:20] motorState == ST_RAMP);

endmodule

// ===== shared/ssrc_pkg.sv
`include "ssrc_regs.svh"

package ssrc_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_KICK = 5'h02,
    ST_RAMP = 5'h04,
    ST_RUN  = 5'h08,
    ST_STOP = 5'h10
  } ssrc_state_e;

  typedef enum logic [1:0] {
    RM_MANUAL = `SSRC_RM_MANUAL,
    RM_AUTO   = `SSRC_RM_AUTO,
    RM_PWRUP  = `SSRC_RM_PWRUP
  } ssrc_rmode_e;

  typedef enum logic [1:0] {
    SP_COAST = `SSRC_SP_COAST,
    SP_SOFT  = `SSRC_SP_SOFT,
    SP_PUMP  = `SSRC_SP_PUMP
  } ssrc_stop_e;

  typedef enum logic {PR_VRAMP, PR_CLIMIT} ssrc_prof_e;

  typedef struct packed {
    logic        netCtl;
    logic        localOnly;
    ssrc_rmode_e resetMode;
    ssrc_stop_e  stopType;
    ssrc_prof_e  profile;
  } ssrc_ctrl_s;

  typedef struct packed {
    logic [7:0] kickTime;
    logic [7:0] kickTorque;
    logic [7:0] initTorque;
  } ssrc_level_s;

  typedef struct packed {
    logic [15:0] stopTime;
    logic [15:0] startTime;
  } ssrc_time_s;

  typedef struct packed {
    logic        armed;
    logic        jog;
    logic        runEn;
    logic        localAct;
    logic        levelSense;
    logic        fault;
    ssrc_state_e state;
  } ssrc_status_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic reset;
  } ssrc_cmd_s;

  typedef struct packed {
    logic [7:0] volt;
    logic       kick;
    logic       bypass;
    logic       pump;
  } ssrc_drive_s;

endpackage

// ===== shared/ssrc_regs.svh
`ifndef SSRC_REGS_SVH
`define SSRC_REGS_SVH

// System clock and derived timing
`define SSRC_CLK_HZ      25000000
`define SSRC_TICK_MS     10
`define SSRC_TICK_CYC    (`SSRC_CLK_HZ / 1000 * `SSRC_TICK_MS)
`define SSRC_DEB_MS      5
`define SSRC_DEB_CYC     (`SSRC_CLK_HZ / 1000 * `SSRC_DEB_MS)
`define SSRC_KICK_MAX_S  2
`define SSRC_KICK_MAX_TK (`SSRC_KICK_MAX_S * 1000 / `SSRC_TICK_MS)

// Register byte offsets
`define SSRC_OFS_CTRL    5'h00
`define SSRC_OFS_LEVEL   5'h04
`define SSRC_OFS_TIME    5'h08
`define SSRC_OFS_MAP     5'h0C
`define SSRC_OFS_STATUS  5'h10

// Reset values
`define SSRC_RST_CTRL    7'h00
`define SSRC_RST_LEVEL   24'h00C050
`define SSRC_RST_TIME    32'h03E803E8
`define SSRC_RST_MAP     8'hE4

// Encodings
`define SSRC_RM_MANUAL   2'h0
`define SSRC_RM_AUTO     2'h1
`define SSRC_RM_PWRUP    2'h2
`define SSRC_SP_COAST    2'h0
`define SSRC_SP_SOFT     2'h1
`define SSRC_SP_PUMP     2'h2
`define SSRC_FN_START    2'h0
`define SSRC_FN_JOG      2'h1
`define SSRC_FN_LOCAL    2'h2
`define SSRC_FN_RESET    2'h3
`define SSRC_V_FULL      8'hFF
`define SSRC_V_ZERO      8'h00

`endif

// ===== tb/ssrc_far_side.sv
module ssrc_far_side
  import ssrc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       enLvl,
  input  wire logic [3:0] termLvl,
  input  wire ssrc_cmd_s  netReq,
  input  wire ssrc_cmd_s  dispReq,
  output logic            runEnableIn,
  output logic [3:0]      termIn,
  output ssrc_cmd_s       netCmd,
  output ssrc_cmd_s       dispCmd
);
  timeunit 1ns;
  timeprecision 1ns;

  // Terminal levels and one-cycle command pulses leave the far side on the clock
  always_ff @(posedge clk_sys)
  begin
    runEnableIn <= enLvl;
    termIn      <= termLvl;
    netCmd      <= netReq;
    dispCmd     <= dispReq;
  end
endmodule

// ===== tb/testbench.sv
`include "ssrc_regs.svh"

module testbench;
  import ssrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys = 1'h0;
  logic        rst = 1'h1;
  logic        enLvl = 1'h0;
  logic        sw = 1'h0;
  logic        fAct = 1'h0;
  logic        atSpeed = 1'h0;
  logic [3:0]  termLvl = 4'h0;
  ssrc_cmd_s   netReq = '0;
  ssrc_cmd_s   dispReq = '0;
  logic [4:0]  avAddress = 5'h00;
  logic        avRead = 1'h0;
  logic        avWrite = 1'h0;
  logic [31:0] avWritedata = 32'h0;
  logic [31:0] avReaddata;
  logic        avWaitrequest;
  logic        runEnableIn;
  logic [3:0]  termIn;
  ssrc_cmd_s   netCmd;
  ssrc_cmd_s   dispCmd;
  ssrc_drive_s drive;
  ssrc_state_e motorState;
  logic        faultLatched;
  logic [63:0] rq [$];
  logic [63:0] nt;
  int          stCnt [5] = '{default: 0};
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;

  ssrc_run_control #(.TICK_CYC(20), .DEB_CYC(4)) i_ssrc_run_control (
    .clk_sys(clk_sys), .rst(rst), .runEnableIn(runEnableIn), .termIn(termIn),
    .sensingSelectSwitch(sw), .faultActive(fAct), .atSpeed(atSpeed), .netCmd(netCmd),
    .dispCmd(dispCmd), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
    .avWritedata(avWritedata), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
    .drive(drive), .motorState(motorState), .faultLatched(faultLatched));

  ssrc_far_side i_ssrc_far_side (
    .clk_sys(clk_sys), .enLvl(enLvl), .termLvl(termLvl), .netReq(netReq),
    .dispReq(dispReq), .runEnableIn(runEnableIn), .termIn(termIn), .netCmd(netCmd),
    .dispCmd(dispCmd));

  // System clock, 40 ns period
  always #20 clk_sys = ~clk_sys;

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  // Avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avAddress   <= a;
    avWritedata <= d;
    avWrite     <= wr;
    avRead      <= ~wr;
    do @(posedge clk_sys); while (avWaitrequest !== 1'h0);
    avWrite <= 1'h0;
    avRead  <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({m, e});
    bus(1'h0, a, 32'h0);
  endtask

  task automatic wst(input ssrc_state_e s, input int lim, input string m);
    int n;
    n = 0;
    while (motorState !== s && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(motorState, s, m);
  endtask

  // Longer than sync plus debounce of a terminal change
  task automatic settle;
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic pulse(input logic net, input logic [2:0] c);
    if (net)
      netReq <= ssrc_cmd_s'(c);
    else
      dispReq <= ssrc_cmd_s'(c);
    @(posedge clk_sys);
    netReq  <= '0;
    dispReq <= '0;
    @(posedge clk_sys);
  endtask

  // Read monitor takes the oldest note and counts cycles per state
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < 5; i++)
      if (motorState[i] === 1'h1)
        stCnt[i]++;
    if (avRead && avWaitrequest === 1'h0)
    begin
      nt = rq.pop_front();
      chk(avReaddata & nt[63:32], nt[31:0], "read data");
    end
  end

  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    logic [7:0] it;
    logic [7:0] kt;
    int         k0;
    void'($urandom(32'h8FD6DDCA));
    it = 8'($urandom);
    kt = 8'($urandom);
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    // Reset values, register map and reset-mode codes
    chk(motorState, ST_IDLE, "reset state");
    chk(drive, 11'h0, "reset drive");
    chk(faultLatched, 1'h0, "reset fault");
    rd(`SSRC_OFS_CTRL, `SSRC_RST_CTRL, '1);
    rd(`SSRC_OFS_LEVEL, `SSRC_RST_LEVEL, '1);
    rd(`SSRC_OFS_TIME, `SSRC_RST_TIME, '1);
    rd(`SSRC_OFS_MAP, `SSRC_RST_MAP, '1);
    rd(5'h14, 32'h0, '1);
    rd(`SSRC_OFS_STATUS, 32'h01, 32'h7F);
    for (int m = 0; m < 3; m++)
    begin
      bus(1'h1, `SSRC_OFS_CTRL, 32'(m) << 3);
      rd(`SSRC_OFS_CTRL, 32'(m) << 3, '1);
    end
    // 16 ticks leave the ramps room for one voltage step per cycle
    bus(1'h1, `SSRC_OFS_TIME, 32'h00100010);
    bus(1'h1, `SSRC_OFS_LEVEL, {8'h00, 8'h02, kt, it});
    rd(`SSRC_OFS_LEVEL, {8'h00, 8'h02, kt, it}, '1);
    $display("T1 done");
    // Start refused without enable
    termLvl <= 4'h5;
    settle();
    chk(motorState, ST_IDLE, "start without enable");
    termLvl <= 4'h4;
    settle();
    // Kick in both profiles, then enable drop
    for (int p = 0; p < 2; p++)
    begin
      bus(1'h1, `SSRC_OFS_CTRL, 32'(p));
      enLvl   <= 1'h1;
      termLvl <= 4'h5;
      wst(ST_KICK, 30, "kick entry");
      repeat (2) @(posedge clk_sys);
      chk(drive.kick, 1'h1, "kick flag");
      wst(ST_RAMP, 70, "kick length");
      if (p == 1)
      begin
        repeat (3) @(posedge clk_sys);
        chk(drive.volt, it, "limit voltage");
        repeat (40) @(posedge clk_sys);
        chk(drive.volt, it, "limit held");
      end
      wst(ST_RUN, 400, "reach run");
      termLvl <= 4'h4;
      settle();
      chk(motorState, ST_RUN, "momentary start");
      chk(drive.bypass, 1'h1, "bypass closed");
      enLvl <= 1'h0;
      wst(ST_IDLE, 30, "coast on enable drop");
      settle();
    end
    $display("T2 done");
    // Soft stop with kick disabled
    bus(1'h1, `SSRC_OFS_LEVEL, {8'h00, 8'h00, kt, it});
    bus(1'h1, `SSRC_OFS_CTRL, 32'h2);
    k0 = stCnt[1];
    enLvl   <= 1'h1;
    termLvl <= 4'h5;
    wst(ST_RAMP, 30, "ramp entry");
    chk(stCnt[1] - k0, 0, "kick skipped");
    atSpeed <= 1'h1;
    wst(ST_RUN, 5, "at speed ends ramp");
    atSpeed <= 1'h0;
    termLvl <= 4'h4;
    enLvl   <= 1'h0;
    k0 = stCnt[4];
    wst(ST_STOP, 20, "soft stop entry");
    wst(ST_IDLE, 400, "soft stop end");
    chk(stCnt[4] - k0 >= 300, 1'h1, "soft stop length");
    repeat (2) @(posedge clk_sys);
    chk(drive.volt, `SSRC_V_ZERO, "voltage zero");
    $display("T3 done");
    // Jog needs local, never bypasses, release coasts
    termLvl <= 4'h2;
    enLvl   <= 1'h1;
    settle();
    chk(motorState, ST_IDLE, "jog without local");
    termLvl <= 4'h6;
    wst(ST_RAMP, 20, "jog start");
    wst(ST_RUN, 400, "jog run");
    repeat (3) @(posedge clk_sys);
    chk(drive.bypass, 1'h0, "jog bypass");
    k0 = stCnt[4];
    termLvl <= 4'h4;
    wst(ST_IDLE, 20, "jog release");
    chk(stCnt[4] - k0, 0, "jog coast");
    // Terminal 2 remapped to start keeps running after release
    bus(1'h1, `SSRC_OFS_MAP, 32'hE0);
    termLvl <= 4'h6;
    settle();
    termLvl <= 4'h4;
    settle();
    chk(motorState === ST_IDLE, 1'h0, "remapped start");
    bus(1'h1, `SSRC_OFS_CTRL, 32'h4);
    enLvl <= 1'h0;
    wst(ST_STOP, 20, "pump stop entry");
    @(posedge clk_sys);
    chk(drive.pump, 1'h1, "pump drive");
    wst(ST_IDLE, 400, "stop");
    bus(1'h1, `SSRC_OFS_MAP, 32'hE4);
    $display("T4 done");
    // Network and display commands
    bus(1'h1, `SSRC_OFS_CTRL, 32'h40);
    termLvl <= 4'h0;
    enLvl   <= 1'h1;
    settle();
    pulse(1'h1, 3'h4);
    wst(ST_RAMP, 10, "net start");
    pulse(1'h1, 3'h2);
    wst(ST_IDLE, 10, "net stop");
    termLvl <= 4'h4;
    settle();
    pulse(1'h1, 3'h4);
    repeat (10) @(posedge clk_sys);
    chk(motorState, ST_IDLE, "net under local");
    pulse(1'h0, 3'h4);
    wst(ST_RAMP, 10, "display start");
    pulse(1'h0, 3'h2);
    wst(ST_IDLE, 10, "display stop");
    $display("T5 done");
    // Fault latch, reset and edge sensing
    bus(1'h1, `SSRC_OFS_CTRL, 32'h0);
    termLvl <= 4'h5;
    wst(ST_RAMP, 20, "start");
    fAct <= 1'h1;
    wst(ST_IDLE, 10, "fault trip");
    chk(faultLatched, 1'h1, "fault latched");
    termLvl <= 4'hD;
    settle();
    chk(faultLatched, 1'h1, "reset while active");
    fAct <= 1'h0;
    repeat (3) @(posedge clk_sys);
    chk(faultLatched, 1'h0, "reset after clear");
    termLvl <= 4'h5;
    settle();
    chk(motorState, ST_IDLE, "held start after fault");
    termLvl <= 4'h4;
    settle();
    termLvl <= 4'h5;
    wst(ST_RAMP, 20, "start re-edge");
    fAct <= 1'h1;
    wst(ST_IDLE, 10, "fault trip");
    fAct <= 1'h0;
    repeat (3) @(posedge clk_sys);
    chk(faultLatched, 1'h1, "manual latch");
    pulse(1'h1, 3'h1);
    @(posedge clk_sys);
    chk(faultLatched, 1'h0, "net reset");
    enLvl <= 1'h0;
    settle();
    $display("T6 done");
    // Level sensing with automatic reset
    sw <= 1'h1;
    bus(1'h1, `SSRC_OFS_CTRL, 32'h08);
    enLvl   <= 1'h1;
    termLvl <= 4'h4;
    settle();
    rd(`SSRC_OFS_STATUS, 32'h40, 32'h40);
    termLvl <= 4'h5;
    wst(ST_RAMP, 20, "level start");
    fAct <= 1'h1;
    wst(ST_IDLE, 10, "fault trip");
    fAct <= 1'h0;
    wst(ST_RAMP, 30, "auto restart");
    enLvl <= 1'h0;
    wst(ST_IDLE, 20, "enable drop");
    enLvl <= 1'h1;
    wst(ST_RAMP, 30, "enable return");
    $display("T7 done");
    stop_test();
  end
endmodule
